//--- verilog/tcu_top.sv
/*
 timer unit clock gate, prescaler, four channels with mode, triggers and stop,
 interrupt flags, behind an AHB-Lite slave.
 assumes one clock hclk; ext_timer_in is an asynchronous pin.
 register words, byte offsets:
   00 clock gate, bit 0 only
   04 stop trigger, write-only strobe: 3..0 channels, 9 and 11 upper halves
   08 prescaler, two 4-bit divider fields
   0c interrupt mask, one bit per channel
   10 interrupt request, device set wins over a software clear
   14 priority bit 0, 18 priority bit 1, one bit per channel each
   20, 24, 28, 2c channel modes, reserved bits read zero
   30 software start, write-only strobe: 3..0 lower, 11..8 upper halves
   34 running status, upper halves in 11..8
   38 block event status, cleared by its read; 3c its mask
 assumes zero wait states are acceptable to the master; hreadyout and hresp
 are constant but registered so every output leaves a flip-flop.
 assumes channel 0 is the master for slaves on the master trigger.
 limitation: the prescaler counter runs only while the gate is set, so a
 divided clock restarts its phase from where it stopped.
 limitation: the pin passes a three-stage synchroniser, so edges closer
 than about two clocks may merge.
 limitation: captured counts are kept per channel but have no read word.
*/
// Functional notes
// - timer unit counts on its clock only while clock gate bit 0 is one.
// - writing one to a channel stop bit clears its running flag; zero ignored.
// - stop register bits 9 and 11 stop upper halves of channels 1 and 3.
// - prescaler bits 3..0 divide system clock by two to that power.
// - prescaler bits 7..4 make second clock; clock-select bit chooses between them.
// - count-source bit picks operation clock or external input valid edge.
// - split bit selects one 16-bit timer or two 8-bit halves.
// - trigger field 000 starts only by software trigger.
// - trigger field 001 uses the valid external edge for start and capture.
// - trigger field 010 uses both external edges for start and capture.
// - trigger field 100 takes master channel interrupt as trigger.
// - mode register layout: cks 15, ccs 12, split 11, sts 10..8, cis 7..6, md 3..0.
// - mask flag zero lets interrupt through, one blocks it.
// - device sets request flag on event; software may clear it.
// - two priority registers give each interrupt a two-bit level 0..3.
// - edge field selects falling, rising, or both edges.
// - mode field selects interval, capture, event, one-count, capture-one-count.
`timescale 1ns/10ps
`default_nettype none
module tcu_top
#(
    parameter int CNT_W = 16
)
(
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // pin and interrupts
    input  wire logic        ext_timer_in,
    output logic      [3:0]  timer_irq_req,
    output logic             irq
);
    import tcu_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] div_mask(input logic [3:0] sel);
        div_mask = 16'(( 17'h1 << sel) - 17'h1);
    endfunction

    // up-counting modes end at all ones, the others at zero
    function automatic logic mode_up(input logic [15:0] mode);
        mode_up = (mode[MD_LSB+1+:3] == MD_CAPTURE) | (mode[MD_LSB+1+:3] == MD_CAPONE);
    endfunction

    function automatic logic valid_edge(input logic [1:0] cis, input logic rise, input logic fall);
        case (cis)
            CIS_FALL: valid_edge = fall;
            CIS_RISE: valid_edge = rise;
            default:  valid_edge = rise | fall;
        endcase
    endfunction

    logic        gate_reg;
    logic [7:0]  presc_reg;
    logic [3:0]  mask_reg, req_reg, prio0_reg, prio1_reg;
    logic [15:0] mode_reg [TCU_NCH];
    logic [3:0]  run_reg, run_hi_reg;
    logic [CNT_W-1:0] cnt_reg [TCU_NCH];
    logic [CNT_W-1:0] cap_reg [TCU_NCH];
    logic [15:0] pre_reg;
    logic [1:0]  evt_stat_reg, evt_mask_reg;
    logic [2:0]  pin_sync;
    logic        pin_reg;
    logic        a_wr_reg, a_rd_reg;
    logic [7:0]  a_addr_reg;

    ////////////////////////////////////////////////////////////////////////
    // bus address phase captured, data phase one cycle later, zero wait
    wire  take = hsel & hready & htrans[1];
    wire  wr   = a_wr_reg;
    wire  [7:0] wa = a_addr_reg;

    // write strobes of the data phase
    wire  wr_stop  = wr & (wa == ADDR_STOP);
    wire  wr_start = wr & (wa == ADDR_START);

    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
        begin
            a_wr_reg   <= 1'b0;
            a_rd_reg   <= 1'b0;
            a_addr_reg <= 8'h00;
        end
        else
        begin
            a_wr_reg   <= take & hwrite;
            a_rd_reg   <= take & ~hwrite;
            a_addr_reg <= take ? haddr[7:0] : a_addr_reg;
        end

    ////////////////////////////////////////////////////////////////////////
    // pin: three stages, a change counts once stages two and three agree
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
        begin
            pin_sync <= 3'h0;
            pin_reg  <= 1'b0;
        end
        else
        begin
            pin_sync <= {pin_sync[1:0], ext_timer_in};
            if (pin_sync[2] == pin_sync[1])
                pin_reg <= pin_sync[2];
        end
    wire pin_new = (pin_sync[2] == pin_sync[1]) ? pin_sync[2] : pin_reg;
    wire pin_rise = pin_new & ~pin_reg;
    wire pin_fall = ~pin_new & pin_reg;

    ////////////////////////////////////////////////////////////////////////
    // prescaler runs only with the gate; holds otherwise
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
            pre_reg <= 16'h0000;
        else if (gate_reg)
            pre_reg <= pre_reg + 16'h0001;
    wire [15:0] pre_nx = pre_reg + 16'h0001;
    wire ck0 = gate_reg & ((pre_nx & div_mask(presc_reg[3:0])) == 16'h0000);
    wire ck1 = gate_reg & ((pre_nx & div_mask(presc_reg[7:4])) == 16'h0000);

    ////////////////////////////////////////////////////////////////////////
    // per-channel decode; terminal events come first because the
    // master trigger of the slaves reads evt[0]
    logic [3:0] tick, start, stop_lo, stop_hi, capt, evt, up;
    always_comb
    begin
        logic [15:0] m;
        logic        vedge;
        m     = 16'h0000;
        vedge = 1'b0;
        tick  = 4'h0;
        evt   = 4'h0;
        up    = 4'h0;
        for (int n = 0; n < TCU_NCH; n++)
        begin
            m       = mode_reg[n];
            vedge   = valid_edge(m[CIS_LSB+:2], pin_rise, pin_fall);
            up[n]   = mode_up(m);
            tick[n] = gate_reg & (m[CCS_BIT] ? vedge
                    : (m[CKS_BIT] ? ck1 : ck0));
            // down modes end at zero, up modes at full
            evt[n]  = run_reg[n] & tick[n] & (up[n] ? (cnt_reg[n] == '1) : (cnt_reg[n] == '0));
        end
    end

    // start, capture and stop triggers
    always_comb
    begin
        logic [15:0] m;
        m       = 16'h0000;
        start   = 4'h0;
        capt    = 4'h0;
        stop_lo = 4'h0;
        stop_hi = 4'h0;
        for (int n = 0; n < TCU_NCH; n++)
        begin
            m = mode_reg[n];
            case (m[STS_LSB+:3])
                STS_EDGE:   start[n] = gate_reg & valid_edge(m[CIS_LSB+:2], pin_rise, pin_fall);
                STS_BOTH:   start[n] = gate_reg & (pin_rise | pin_fall);
                STS_MASTER: start[n] = gate_reg & (n != 0) & evt[0];
                default:    start[n] = 1'b0;
            endcase
            capt[n]    = start[n] & up[n];
            stop_lo[n] = wr_stop & hwdata[n];
            stop_hi[n] = wr_stop & (((n == 1) & hwdata[UH_STOP_CH1])
                       | ((n == 3) & hwdata[UH_STOP_CH3]));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // running flags; software start register sets, stop wins on same write
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
        begin
            run_reg    <= 4'h0;
            run_hi_reg <= 4'h0;
        end
        else
            for (int n = 0; n < TCU_NCH; n++)
            begin
                if (stop_lo[n])
                    run_reg[n] <= 1'b0;
                else if ((wr_start & hwdata[n] & gate_reg) | start[n])
                    run_reg[n] <= 1'b1;
                else if (evt[n] & (mode_reg[n][MD_LSB+1+:3] >= MD_ONECOUNT))
                    run_reg[n] <= 1'b0;
                if (stop_hi[n])
                    run_hi_reg[n] <= 1'b0;
                else if (wr_start & hwdata[n+8] & gate_reg & mode_reg[n][SPLIT_BIT])
                    run_hi_reg[n] <= 1'b1;
            end

    // counters: split makes two independent byte halves
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
            for (int n = 0; n < TCU_NCH; n++)
            begin
                cnt_reg[n] <= '0;
                cap_reg[n] <= '0;
            end
        else
            for (int n = 0; n < TCU_NCH; n++)
            begin
                if (capt[n])
                begin
                    cap_reg[n] <= cnt_reg[n];
                    cnt_reg[n] <= '0;
                end
                else if (mode_reg[n][SPLIT_BIT])
                begin
                    if (run_reg[n] & tick[n])
                        cnt_reg[n][7:0] <= up[n] ? cnt_reg[n][7:0] + 8'h01 : cnt_reg[n][7:0] - 8'h01;
                    if (run_hi_reg[n] & tick[n])
                        cnt_reg[n][15:8] <= up[n] ? cnt_reg[n][15:8] + 8'h01 : cnt_reg[n][15:8] - 8'h01;
                end
                else if (run_reg[n] & tick[n])
                    cnt_reg[n] <= up[n] ? cnt_reg[n] + 1'b1 : cnt_reg[n] - 1'b1;
            end

    ////////////////////////////////////////////////////////////////////////
    // config registers, one process each
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
            gate_reg <= 1'b0;
        else if (wr & (wa == ADDR_CLK_GATE))
            gate_reg <= hwdata[GATE_BIT];

    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
            presc_reg <= 8'h00;
        else if (wr & (wa == ADDR_PRESCALE))
            presc_reg <= hwdata[7:0];

    // all interrupts start masked and at the lowest priority
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
            mask_reg <= 4'hf;
        else if (wr & (wa == ADDR_IRQ_MASK))
            mask_reg <= hwdata[3:0];

    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
            prio0_reg <= 4'hf;
        else if (wr & (wa == ADDR_PRIO0))
            prio0_reg <= hwdata[3:0];

    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
            prio1_reg <= 4'hf;
        else if (wr & (wa == ADDR_PRIO1))
            prio1_reg <= hwdata[3:0];

    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
            evt_mask_reg <= 2'h0;
        else if (wr & (wa == ADDR_EVT_MASK))
            evt_mask_reg <= hwdata[1:0];

    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
            for (int n = 0; n < TCU_NCH; n++)
                mode_reg[n] <= 16'h0000;
        else if (wr)
            for (int n = 0; n < TCU_NCH; n++)
                if (wa == ADDR_MODE0 + 8'(4 * n))
                    mode_reg[n] <= hwdata[15:0] & MODE_RMASK;

    // request flags: device set wins over software clear
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
            req_reg <= 4'h0;
        else
            req_reg <= ((wr & (wa == ADDR_IRQ_REQ)) ? hwdata[3:0] : req_reg) | evt;

    // block events: bad mode, stop of idle channel; clear on read
    wire bad_mode = wr && (wa[7:4] == ADDR_MODE0[7:4]) && !(hwdata[3:1] inside
                    {MD_INTERVAL, MD_CAPTURE, MD_EVENT, MD_ONECOUNT, MD_CAPONE});
    wire idle_stop = |(stop_lo & ~run_reg);
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
            evt_stat_reg <= 2'h0;
        else
            evt_stat_reg <= ((a_rd_reg & (wa == ADDR_EVT_STAT)) ? 2'h0 : evt_stat_reg)
                          | {idle_stop, bad_mode};

    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
        begin
            irq           <= 1'b0;
            timer_irq_req <= 4'h0;
        end
        else
        begin
            irq           <= |(evt_stat_reg & evt_mask_reg);
            timer_irq_req <= req_reg & ~mask_reg;
        end

    ////////////////////////////////////////////////////////////////////////
    // read data registered at the address phase; stop register reads zero
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
            hrdata <= 32'h0000_0000;
        else if (take & ~hwrite)
        begin
            hrdata <= 32'h0000_0000;
            case (haddr[7:0])
                ADDR_CLK_GATE: hrdata[GATE_BIT] <= gate_reg;
                ADDR_PRESCALE: hrdata[7:0] <= presc_reg;
                ADDR_IRQ_MASK: hrdata[3:0] <= mask_reg;
                ADDR_IRQ_REQ:  hrdata[3:0] <= req_reg;
                ADDR_PRIO0:    hrdata[3:0] <= prio0_reg;
                ADDR_PRIO1:    hrdata[3:0] <= prio1_reg;
                ADDR_STATUS:   hrdata[11:0] <= {run_hi_reg, 4'h0, run_reg};
                ADDR_EVT_STAT: hrdata[1:0] <= evt_stat_reg;
                ADDR_EVT_MASK: hrdata[1:0] <= evt_mask_reg;
                default:
                    for (int n = 0; n < TCU_NCH; n++)
                        if (haddr[7:0] == ADDR_MODE0 + 8'(4 * n))
                            hrdata[15:0] <= mode_reg[n];
            endcase
        end

    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
endmodule
`default_nettype wire

//--- verilog/tcu_pkg.sv
/*
 register map, field positions and mode codes of the timer configuration block.
 assumes a 32-bit AHB-Lite slave, one word per register.
*/
`default_nettype none
package tcu_pkg;
    localparam int          TCU_NCH         = 4;
    localparam logic [7:0]  ADDR_CLK_GATE   = 8'h00;
    localparam logic [7:0]  ADDR_STOP       = 8'h04;
    localparam logic [7:0]  ADDR_PRESCALE   = 8'h08;
    localparam logic [7:0]  ADDR_IRQ_MASK   = 8'h0c;
    localparam logic [7:0]  ADDR_IRQ_REQ    = 8'h10;
    localparam logic [7:0]  ADDR_PRIO0      = 8'h14;
    localparam logic [7:0]  ADDR_PRIO1      = 8'h18;
    localparam logic [7:0]  ADDR_MODE0      = 8'h20;
    localparam logic [7:0]  ADDR_START      = 8'h30;
    localparam logic [7:0]  ADDR_STATUS     = 8'h34;
    localparam logic [7:0]  ADDR_EVT_STAT   = 8'h38;
    localparam logic [7:0]  ADDR_EVT_MASK   = 8'h3c;
    localparam int          GATE_BIT        = 0;
    localparam int          UH_STOP_CH1     = 9;
    localparam int          UH_STOP_CH3     = 11;
    localparam int          CKS_BIT         = 15;
    localparam int          CCS_BIT         = 12;
    localparam int          SPLIT_BIT       = 11;
    localparam int          STS_LSB         = 8;
    localparam int          CIS_LSB         = 6;
    localparam int          MD_LSB          = 0;
    localparam logic [15:0] MODE_RMASK      = 16'h9fcf;
    localparam logic [2:0]  STS_SOFT        = 3'h0;
    localparam logic [2:0]  STS_EDGE        = 3'h1;
    localparam logic [2:0]  STS_BOTH        = 3'h2;
    localparam logic [2:0]  STS_MASTER      = 3'h4;
    localparam logic [1:0]  CIS_FALL        = 2'h0;
    localparam logic [1:0]  CIS_RISE        = 2'h1;
    localparam logic [2:0]  MD_INTERVAL     = 3'h0;
    localparam logic [2:0]  MD_CAPTURE      = 3'h2;
    localparam logic [2:0]  MD_EVENT        = 3'h3;
    localparam logic [2:0]  MD_ONECOUNT     = 3'h4;
    localparam logic [2:0]  MD_CAPONE       = 3'h6;
    localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;
endpackage
`default_nettype wire

//--- tb/tcu_top_asserts.sv
/*
 port checker for tcu_top, bound under the design.
 assumes word transfers at addresses below 8'h80.
*/
`timescale 1ns/10ps
`default_nettype none
module tcu_top_asserts
import tcu_pkg::*;
#(
    parameter int CNT_W = 16
)
(
    // clock and reset
    input wire logic        hclk,
    input wire logic        hresetn,
    // ahb-lite
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // pin and interrupts
    input wire logic        ext_timer_in,
    input wire logic [3:0]  timer_irq_req,
    input wire logic        irq
);
////////////////////////////////////////
logic       rd_p;
logic       wr_p;
logic [7:0] a_p;
wire logic  take = hsel && hready && htrans[1];
// data phase tracking, address kept for the data edge
always_ff @(posedge hclk or negedge hresetn)
begin
    if (!hresetn)
    begin
        rd_p <= 1'b0;
        wr_p <= 1'b0;
    end
    else
    begin
        rd_p <= take && !hwrite;
        wr_p <= take && hwrite;
    end
end
always_ff @(posedge hclk)
begin
    if (take)
        a_p <= haddr[7:0];
end
////////////////////////////////////////
default clocking cb @(posedge hclk); endclocking
default disable iff (!hresetn);
ready_high_a: assert property (hreadyout) else $error("wait state seen");
resp_okay_a: assert property (!hresp) else $error("error response seen");
rdata_hold_a: assert property (!(take && !hwrite) |=> $stable(hrdata)) else $error("read data moved");
stop_reads_zero_a: assert property (rd_p && a_p == ADDR_STOP |-> hrdata == 32'h0)
    else $error("stop register not zero");
gate_read_a: assert property (rd_p && a_p == ADDR_CLK_GATE |-> hrdata[31:1] == 31'h0)
    else $error("gate upper bits set");
presc_read_a: assert property (rd_p && a_p == ADDR_PRESCALE |-> hrdata[31:8] == 24'h0)
    else $error("prescaler upper bits set");
mode_read_a: assert property (rd_p && a_p[7:4] == 4'h2 |-> (hrdata & ~{16'h0, MODE_RMASK}) == 32'h0)
    else $error("mode reserved bits set");
mask_blocks_a: assert property (wr_p && a_p == ADDR_IRQ_MASK && hwdata[3:0] == 4'hf
    |-> ##[2:3] timer_irq_req == 4'h0)
    else $error("masked request still out");
unmapped_zero_a: assert property (rd_p && a_p >= 8'h40 |-> hrdata == 32'h0) else $error("unmapped read not zero");
cover property (rd_p && a_p == ADDR_STATUS);
cover property ($rose(irq));
cover property ($rose(timer_irq_req[0]));
endmodule
bind tcu_top tcu_top_asserts #(.CNT_W(CNT_W)) tcu_top_asserts_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .ext_timer_in(ext_timer_in), .timer_irq_req(timer_irq_req), .irq(irq)
);
`default_nettype wire

//--- tb/tcu_top_tb_top.sv
/*
 testbench for tcu_top: register table, start and stop, pin triggers, interrupts.
 assumes the checker file binds itself in.
*/
`timescale 1ns/10ps
`default_nettype none
module tcu_top_tb_top;
import tcu_pkg::*;
typedef struct packed
{
    logic [7:0]  a;
    logic        w;
    logic [31:0] d;
    logic [31:0] e;
} tcu_row_t;
logic        hclk;
logic        hresetn;
logic        hsel;
logic [31:0] haddr;
logic [1:0]  htrans;
logic        hwrite;
logic [2:0]  hsize;
logic [31:0] hwdata;
logic        ext_timer_in;
logic [31:0] hrdata;
logic        hreadyout;
logic        hresp;
logic [3:0]  timer_irq_req;
logic        irq;
logic [31:0] rv;
int          err_total;
int          checks_done;
int          cyc;
// reset values first, then write and read back
localparam tcu_row_t ROWS [17] = '{
    '{ADDR_CLK_GATE, 1'b0, 32'h0, 32'h0}, '{ADDR_PRESCALE, 1'b0, 32'h0, 32'h0},
    '{ADDR_IRQ_MASK, 1'b0, 32'h0, 32'hf}, '{ADDR_IRQ_REQ, 1'b0, 32'h0, 32'h0},
    '{ADDR_PRIO0, 1'b0, 32'h0, 32'hf}, '{ADDR_PRIO1, 1'b0, 32'h0, 32'hf},
    '{ADDR_MODE0, 1'b0, 32'h0, 32'h0}, '{ADDR_STATUS, 1'b0, 32'h0, 32'h0},
    '{ADDR_CLK_GATE, 1'b1, 32'hffffffff, 32'h1}, '{ADDR_PRESCALE, 1'b1, 32'hffffffff, 32'hff},
    '{ADDR_PRIO0, 1'b1, 32'h5, 32'h5}, '{ADDR_PRIO1, 1'b1, 32'ha, 32'ha},
    '{ADDR_MODE0, 1'b1, 32'hffffffff, 32'h9fcf}, '{8'h24, 1'b1, 32'h0800, 32'h0800},
    '{ADDR_IRQ_MASK, 1'b1, 32'h3e, 32'he}, '{ADDR_STOP, 1'b1, 32'hffffffff, 32'h0},
    '{8'h40, 1'b1, 32'hffffffff, 32'h0}
};
tcu_top tcu_top_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .ext_timer_in(ext_timer_in), .timer_irq_req(timer_irq_req), .irq(irq)
);
////////////////////////////////////////
task automatic end_sim();
    if (err_total == 0 && checks_done > 0)
        $display("== PASSED ==");
    else
        $display("== FAILED ==");
    $finish;
endtask
task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
        err_total++;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
endtask
task automatic chk_pin(input logic [3:0] got, input logic [3:0] exp);
    checks_done++;
    if (got !== exp)
    begin
        err_total++;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
endtask
// one single word transfer; no wait count assumed
task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    htrans <= HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
        @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
        @(posedge hclk);
    rv = hrdata;
endtask
task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
endtask
task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk_reg(rv, e);
endtask
////////////////////////////////////////
initial
begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
end
// limit covers one full 16-bit countdown plus margin
always @(posedge hclk)
begin
    cyc <= cyc + 1;
    if (cyc == 90000)
    begin
        err_total++;
        end_sim();
    end
end
initial
begin
    {hresetn, hsel, haddr, htrans, hwrite, hwdata, ext_timer_in} = '0;
    hsize = 3'h2;
    {err_total, checks_done, cyc} = '0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    hsel <= 1'b1;
    foreach (ROWS[i])
    begin
        if (ROWS[i].w)
            wr(ROWS[i].a, ROWS[i].d);
        rdc(ROWS[i].a, ROWS[i].e);
    end
    rdc(ADDR_EVT_STAT, 32'h3);
    rdc(ADDR_EVT_STAT, 32'h0);
    wr(ADDR_EVT_MASK, 32'h2);
    wr(ADDR_STOP, 32'h4);
    repeat (3) @(posedge hclk);
    chk_pin({3'h0, irq}, 4'h1);
    rdc(ADDR_EVT_STAT, 32'h2);
    repeat (3) @(posedge hclk);
    chk_pin({3'h0, irq}, 4'h0);
    wr(ADDR_PRESCALE, 32'h0);
    wr(ADDR_MODE0, 32'h0);
    wr(ADDR_START, 32'h203);
    rdc(ADDR_STATUS, 32'h203);
    wr(ADDR_STOP, 32'h0);
    rdc(ADDR_STATUS, 32'h203);
    wr(ADDR_STOP, 32'h200);
    rdc(ADDR_STATUS, 32'h3);
    wr(ADDR_STOP, 32'h2);
    rdc(ADDR_STATUS, 32'h1);
    // both channels start at zero, so their terminal events come at once
    for (int n = 0; n < 70000 && timer_irq_req[0] !== 1'b1; n++)
        @(posedge hclk);
    chk_pin(timer_irq_req, 4'h1);
    rdc(ADDR_IRQ_REQ, 32'h3);
    wr(ADDR_IRQ_MASK, 32'hf);
    repeat (2) @(posedge hclk);
    chk_pin(timer_irq_req, 4'h0);
    wr(ADDR_STOP, 32'h1);
    wr(ADDR_IRQ_REQ, 32'h0);
    rdc(ADDR_IRQ_REQ, 32'h0);
    rdc(ADDR_STATUS, 32'h0);
    wr(8'h28, 32'h0100);
    wr(8'h2c, 32'h0);
    ext_timer_in <= 1'b1;
    repeat (8) @(posedge hclk);
    rdc(ADDR_STATUS, 32'h0);
    ext_timer_in <= 1'b0;
    repeat (8) @(posedge hclk);
    rdc(ADDR_STATUS, 32'h4);
    wr(ADDR_STOP, 32'h4);
    wr(8'h28, 32'h0200);
    ext_timer_in <= 1'b1;
    repeat (8) @(posedge hclk);
    rdc(ADDR_STATUS, 32'h4);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rdc(ADDR_CLK_GATE, 32'h0);
    end_sim();
end
endmodule
`default_nettype wire
